// ---- bench/gex_pin_model.sv ----
// far-side model of the eight port pins: weak pull-up plus a bench source
// assumes pin_oe is high while the design drives a pin
module gex_pin_model (
   // design side
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe,
   // external source standing in for board logic
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   // resolved level fed back to the design
   output logic [7:0] pin_i
);
   // driven pin wins; a released pin shows the source or else the pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) begin
            pin_i[i] = pin_o[i];
         end else if (ext_en[i]) begin
            pin_i[i] = ext_val[i];
         end else begin
            pin_i[i] = 1'b1;
         end
      end
   end
endmodule

// ---- bench/gex_port_bench.sv ----
// bench for the gpio expander port: apb master tasks and directed tests
// assumes a zero-wait apb slave and the pin model on the port side
module gex_port_bench
   import gex_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // bench-driven inputs
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
   logic [31:0] pwdata = 32'h0;
   // design outputs and resolved pin levels
   logic [31:0] prdata;
   logic pready, pslverr, change_int_n_o, change_int_n_oe, irq;
   logic [7:0] pin_i, pin_o, pin_oe, high_side_driver, low_side_driver;
   // results of the last transfer
   logic [31:0] rd;
   logic er;
   int mismatches = 0;
   int num_checks = 0;
   // reset values per pointer, slot 0 unused
   logic [7:0] rst_tbl [4] = '{8'h00, 8'hff, 8'h00, 8'hff};
   always #2 pclk = ~pclk;
   gex_port uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_pin_i(pin_i), .port_pin_o(pin_o), .port_pin_oe(pin_oe),
      .high_side_driver(high_side_driver), .low_side_driver(low_side_driver),
      .change_int_n_o(change_int_n_o), .change_int_n_oe(change_int_n_oe), .irq(irq));
   gex_pin_model pins (.pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
      .pin_i(pin_i));
   // verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // value compare, an unknown bit matches only an unknown bit
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // bounded wait: a stuck slave must not hang the run
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         $display("ERROR %0t: no pready", $time);
         conclude();
      end
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // bounded wait for the interrupt pin enable to reach a level
   task automatic wait_int(input logic v);
      int n;
      n = 0;
      while (change_int_n_oe !== v && n < 10) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, change_int_n_oe}, {31'h0, v});
      if (n >= 10) conclude();
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({16'h0, high_side_driver, low_side_driver}, 32'h0);
      chk({29'h0, irq, change_int_n_oe, change_int_n_o}, 32'h0);
      rd_chk(GEX_OFS_POINTER, 32'h0);
      for (int p = 1; p < 4; p++) begin
         wr(GEX_OFS_POINTER, 32'(p));
         rd_chk(GEX_OFS_DATA, {24'h0, rst_tbl[p]});
      end
      $display("test reset done");
      wr(GEX_OFS_POINTER, 32'h2);
      wr(GEX_OFS_DATA, 32'h0f);
      wr(GEX_OFS_DATA, 32'ha5);
      rd_chk(GEX_OFS_DATA, 32'ha5);
      rd_chk(GEX_OFS_DATA, 32'ha5);
      rd_chk(GEX_OFS_POINTER, 32'h2);
      wr(GEX_OFS_POINTER, 32'h1);
      wr(GEX_OFS_DATA, 32'h3c);
      wr(GEX_OFS_POINTER, 32'h3);
      wr(GEX_OFS_DATA, 32'hf0);
      repeat (2) @(posedge pclk);
      chk({16'h0, high_side_driver, low_side_driver}, 32'h0c03);
      chk({24'h0, pin_oe}, 32'h0f);
      chk({24'h0, pin_o}, 32'h3c);
      wr(GEX_OFS_POINTER, 32'h0);
      rd_chk(GEX_OFS_DATA, 32'h59);
      wr(GEX_OFS_DATA, 32'h00);
      rd_chk(GEX_OFS_DATA, 32'h59);
      wr(GEX_OFS_POINTER, 32'h1);
      rd_chk(GEX_OFS_DATA, 32'h3c);
      $display("test registers done");
      // data events set status bit 1 but stay masked
      rd_chk(GEX_OFS_IRQ_STAT, 32'h2);
      chk({31'h0, irq}, 32'h0);
      wr(GEX_OFS_IRQ_MASK, 32'h1);
      ext_en <= 8'h80;
      wait_int(1'b1);
      ext_en <= 8'h00;
      wait_int(1'b0);
      wr(GEX_OFS_POINTER, 32'h0);
      ext_en <= 8'h80;
      wait_int(1'b1);
      chk({31'h0, irq}, 32'h1);
      rd_chk(GEX_OFS_DATA, 32'hd9);
      wait_int(1'b0);
      repeat (4) @(posedge pclk);
      chk({31'h0, change_int_n_oe}, 32'h0);
      rd_chk(GEX_OFS_IRQ_STAT, 32'h3);
      wr(GEX_OFS_IRQ_STAT, 32'h3);
      rd_chk(GEX_OFS_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("test interrupt done");
      apb(1'b0, 8'h14, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      $display("test unmapped done");
      conclude();
   end
endmodule

// ---- rtl/gex_pin_cell.sv ----
// one port pin: driver steering and two-flop input synchroniser
// assumes the pin level arrives asynchronously to pclk
module gex_pin_cell (
   // clocking
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // control
   input wire logic dir_in,
   input wire logic latch_bit,
   // pin
   input wire logic pin_i,
   output logic high_side_driver,
   output logic low_side_driver,
   output logic pin_o,
   output logic pin_oe,
   output logic level
);
   logic meta_q; // first stage, read only by level stage
   logic sync_q;

   // input is an output too when driven, so a pin reads its own level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else if (ce) begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end
   assign level = sync_q;

   // input: both drivers off; output: exactly one on
   assign high_side_driver = !dir_in && latch_bit;
   assign low_side_driver = !dir_in && !latch_bit;
   assign pin_oe = !dir_in;
   assign pin_o = latch_bit;
endmodule

// ---- rtl/gex_pkg.sv ----
// package for the gpio expander port block: register map, layouts, resets
// assumes a 32-bit apb slave clocked by pclk at 250 mhz
package gex_pkg;
   // pointer values decoded from the pointer byte
   localparam logic [1:0] GEX_PTR_INPUT = 2'h0;
   localparam logic [1:0] GEX_PTR_OUTPUT = 2'h1;
   localparam logic [1:0] GEX_PTR_POLARITY = 2'h2;
   localparam logic [1:0] GEX_PTR_DIRECTION = 2'h3;
   // apb byte addresses
   localparam logic [7:0] GEX_OFS_POINTER = 8'h00; // pointer byte, write selects register
   localparam logic [7:0] GEX_OFS_DATA = 8'h04; // data byte at the selected register
   localparam logic [7:0] GEX_OFS_IRQ_STAT = 8'h08; // sticky events, write one to clear
   localparam logic [7:0] GEX_OFS_IRQ_MASK = 8'h0c; // enable per event
   localparam logic [7:0] GEX_OFS_STATUS = 8'h10; // live state, read only
   // irq status bit positions
   localparam int GEX_EV_CHANGE = 0; // change-detect line went active
   localparam int GEX_EV_DATA = 1; // data byte transferred
   localparam int GEX_EV_NUM = 2;
   // reset values
   localparam logic [7:0] GEX_RST_OUTPUT = 8'hff;
   localparam logic [7:0] GEX_RST_POLARITY = 8'h00;
   localparam logic [7:0] GEX_RST_DIRECTION = 8'hff;
   localparam logic [1:0] GEX_RST_POINTER = 2'h0;
   localparam logic [1:0] GEX_RST_MASK = 2'h0;
endpackage

// ---- rtl/gex_port.sv ----
// gpio expander port: apb register access, pin drivers, change interrupt
// assumes pins are asynchronous; apb master holds requests until pready
//
// Chosen here: the placing of the registers and register access over APB.
module gex_port
   import gex_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // port pins
   input wire logic [WIDTH-1:0] port_pin_i,
   output logic [WIDTH-1:0] port_pin_o,
   output logic [WIDTH-1:0] port_pin_oe,
   output logic [WIDTH-1:0] high_side_driver,
   output logic [WIDTH-1:0] low_side_driver,
   // interrupts
   output logic change_int_n_o,
   output logic change_int_n_oe,
   output logic irq
);
   logic [1:0] pointer_q; // selected register
   logic [WIDTH-1:0] latch_q; // output latch
   logic [WIDTH-1:0] polarity_q; // polarity invert
   logic [WIDTH-1:0] direction_q; // 1 = input
   logic [WIDTH-1:0] snap_q; // reference for change detect
   logic [WIDTH-1:0] level; // synchronised pin levels
   logic [GEX_EV_NUM-1:0] stat_q; // sticky events
   logic [GEX_EV_NUM-1:0] mask_q; // event enables
   logic [GEX_EV_NUM-1:0] ev; // event pulses
   logic [31:0] rdata_q; // registered read data
   logic change; // live mismatch
   logic change_q; // previous mismatch for edge
   logic acc; // apb access phase
   logic wr;
   logic rd;
   logic known; // mapped address
   logic input_read; // data read at input pointer

   // per pin cells
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      gex_pin_cell u_pin (
         .pclk(pclk),
         .presetn(presetn),
         .ce(ce),
         .dir_in(direction_q[i]),
         .latch_bit(latch_q[i]),
         .pin_i(port_pin_i[i]),
         .high_side_driver(high_side_driver[i]),
         .low_side_driver(low_side_driver[i]),
         .pin_o(port_pin_o[i]),
         .pin_oe(port_pin_oe[i]),
         .level(level[i])
      );
   end

   // address decode shared by read and write paths
   function automatic logic is_mapped(input logic [7:0] a);
      return a == GEX_OFS_POINTER || a == GEX_OFS_DATA || a == GEX_OFS_IRQ_STAT ||
         a == GEX_OFS_IRQ_MASK || a == GEX_OFS_STATUS;
   endfunction

   // zero wait state slave; unmapped answers with pslverr
   assign acc = psel && penable && ce;
   assign known = is_mapped(paddr);
   assign wr = acc && pwrite && known;
   assign rd = acc && !pwrite && known;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !known;
   assign prdata = rdata_q;
   assign input_read = rd && paddr == GEX_OFS_DATA && pointer_q == GEX_PTR_INPUT;

   // pointer only changes on a pointer write, never after data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pointer_q <= GEX_RST_POINTER;
      end else if (wr && paddr == GEX_OFS_POINTER) begin
         pointer_q <= pwdata[1:0];
      end
   end

   // data writes land on the selected register; input register ignores them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= GEX_RST_OUTPUT;
         polarity_q <= GEX_RST_POLARITY;
         direction_q <= GEX_RST_DIRECTION;
      end else if (wr && paddr == GEX_OFS_DATA) begin
         case (pointer_q)
            GEX_PTR_OUTPUT: latch_q <= pwdata[WIDTH-1:0];
            GEX_PTR_POLARITY: polarity_q <= pwdata[WIDTH-1:0];
            GEX_PTR_DIRECTION: direction_q <= pwdata[WIDTH-1:0];
            default: ;
         endcase
      end
   end

   // read data, registered so the access edge sees it one cycle on
   // prdata is captured in setup so it is valid in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0;
      end else if (ce && psel && !penable && !pwrite) begin
         rdata_q <= 32'h0;
         case (paddr)
            GEX_OFS_POINTER: rdata_q[1:0] <= pointer_q;
            GEX_OFS_DATA: begin
               case (pointer_q)
                  GEX_PTR_INPUT: rdata_q[WIDTH-1:0] <= level ^ polarity_q;
                  GEX_PTR_OUTPUT: rdata_q[WIDTH-1:0] <= latch_q;
                  GEX_PTR_POLARITY: rdata_q[WIDTH-1:0] <= polarity_q;
                  default: rdata_q[WIDTH-1:0] <= direction_q;
               endcase
            end
            GEX_OFS_IRQ_STAT: rdata_q[GEX_EV_NUM-1:0] <= stat_q;
            GEX_OFS_IRQ_MASK: rdata_q[GEX_EV_NUM-1:0] <= mask_q;
            GEX_OFS_STATUS: rdata_q[WIDTH:0] <= {change, level};
            default: ;
         endcase
      end
   end

   // snapshot taken as the input register read completes
   // snapshot uses the level that was returned, so a move in between still flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snap_q <= {WIDTH{1'b1}};
      end else if (input_read) begin
         snap_q <= rdata_q[WIDTH-1:0] ^ polarity_q;
      end
   end

   // mismatch over input pins; a pin turned to input may mismatch at once
   assign change = |((level ^ snap_q) & direction_q);
   // open drain, active low: drive low only while a change stands
   assign change_int_n_o = 1'b0;
   assign change_int_n_oe = change;

   // edge of the mismatch for the sticky status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         change_q <= 1'b0;
      end else if (ce) begin
         change_q <= change;
      end
   end
   assign ev[GEX_EV_CHANGE] = ce && change && !change_q;
   assign ev[GEX_EV_DATA] = acc && known && paddr == GEX_OFS_DATA;

   // sticky status: set beats a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
      end else if (ce) begin
         if (wr && paddr == GEX_OFS_IRQ_STAT) begin
            stat_q <= (stat_q & ~pwdata[GEX_EV_NUM-1:0]) | ev;
         end else begin
            stat_q <= stat_q | ev;
         end
      end
   end

   // mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= GEX_RST_MASK;
      end else if (wr && paddr == GEX_OFS_IRQ_MASK) begin
         mask_q <= pwdata[GEX_EV_NUM-1:0];
      end
   end
   assign irq = |(stat_q & mask_q);

   // checks next to the logic they guard
   sequence s_input_read;
      input_read;
   endsequence

   a_int_follows_change: assert property (@(posedge pclk) disable iff (!presetn)
      change_int_n_oe == |((level ^ snap_q) & direction_q))
      else $error("interrupt not tied to input mismatch");
   a_change_undone: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && $stable(snap_q) && $stable(direction_q) && level == snap_q) |-> !change_int_n_oe)
      else $error("interrupt held with no mismatch");
   a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
      s_input_read ##1 (level == snap_q && $stable(direction_q)) |-> !change_int_n_oe)
      else $error("input read did not release interrupt");
   a_spurious_ok: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(direction_q[0]) && level[0] != snap_q[0]) |-> change_int_n_oe)
      else $error("switch to input missed mismatch");
   a_input_hiz: assert property (@(posedge pclk) disable iff (!presetn)
      ((high_side_driver | low_side_driver | port_pin_oe) & direction_q) == '0)
      else $error("input pin driven");
   a_one_driver: assert property (@(posedge pclk) disable iff (!presetn)
      (high_side_driver ^ low_side_driver) == ~direction_q
      && (high_side_driver & ~direction_q) == (latch_q & ~direction_q))
      else $error("output driver steering wrong");
   a_ptr_steady: assert property (@(posedge pclk) disable iff (!presetn)
      (acc && paddr == GEX_OFS_DATA) |=> $stable(pointer_q))
      else $error("pointer moved on data access");
   a_ptr_load: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == GEX_OFS_POINTER) |=> pointer_q == $past(pwdata[1:0]))
      else $error("pointer not loaded");
   a_polarity_read: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && psel && !penable && !pwrite && paddr == GEX_OFS_DATA
      && pointer_q == GEX_PTR_INPUT) |=> rdata_q[WIDTH-1:0] == $past(level ^ polarity_q))
      else $error("input read not polarity corrected");
   a_input_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == GEX_OFS_DATA && pointer_q == GEX_PTR_INPUT)
      |=> $stable(latch_q) && $stable(direction_q) && $stable(polarity_q))
      else $error("input register write had effect");

   // second group of checks: status, error path, read data and freeze
   // these look at state the bench reaches only through whole transfers,
   // so a fault here would otherwise show up late as a wrong read value

   // mismatch edge that feeds the sticky change bit
   sequence s_change_rise;
      ce && change && !change_q;
   endsequence

   // setup cycle of a data byte access
   sequence s_data_setup;
      ce && psel && !penable && paddr == GEX_OFS_DATA;
   endsequence

   // access cycle of a data byte access
   sequence s_data_access;
      acc && paddr == GEX_OFS_DATA;
   endsequence

   // a new mismatch must leave its mark in the status register
   a_change_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      s_change_rise |=> stat_q[GEX_EV_CHANGE])
      else $error("change event not recorded");

   // a set status bit stays until software writes a one to it
   a_stat_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && stat_q[GEX_EV_CHANGE]
      && !(wr && paddr == GEX_OFS_IRQ_STAT && pwdata[GEX_EV_CHANGE]))
      |=> stat_q[GEX_EV_CHANGE])
      else $error("status bit lost without clear");

   // event and clear in one cycle: the event must survive
   a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && change && !change_q && wr && paddr == GEX_OFS_IRQ_STAT)
      |=> stat_q[GEX_EV_CHANGE])
      else $error("clear beat a same-cycle event");

   // level interrupt follows unmasked status only
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq == |(stat_q & mask_q))
      else $error("irq not status and mask");

   // open drain pin can only ever pull low
   a_int_pin_low: assert property (@(posedge pclk) disable iff (!presetn)
      change_int_n_o == 1'b0)
      else $error("interrupt pin driven high");

   // reference after an input read is the raw level that was returned
   a_snap_load: assert property (@(posedge pclk) disable iff (!presetn)
      input_read |=> snap_q == $past(rdata_q[WIDTH-1:0] ^ polarity_q))
      else $error("snapshot not taken from read value");

   // output register reads return the latch, never the pins
   a_output_read: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && psel && !penable && !pwrite && paddr == GEX_OFS_DATA
      && pointer_q == GEX_PTR_OUTPUT) |=> rdata_q[WIDTH-1:0] == $past(latch_q))
      else $error("output read not from latch");

   // registers are at most one byte wide, status one bit more; nothing above the status word reads back
   a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
      rdata_q[31:WIDTH+1] == '0)
      else $error("upper read bits not zero");

   // unmapped access answers at once with an error
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !known) |-> pslverr && pready)
      else $error("unmapped access without error");

   // unmapped access has no side effect on the register set
   a_unmapped_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !known)
      |=> $stable(pointer_q) && $stable(latch_q) && $stable(mask_q))
      else $error("unmapped access changed state");

   // a whole data transfer, setup then access, leaves the pointer alone
   a_data_pointer: assert property (@(posedge pclk) disable iff (!presetn)
      s_data_setup ##1 s_data_access |=> $stable(pointer_q))
      else $error("pointer moved over data transfer");

   // clock enable low freezes every register of the block
   // limitation: pins are not sampled either, so a short pulse may be missed
   a_ce_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      !ce |=> $stable(pointer_q) && $stable(latch_q) && $stable(direction_q)
      && $stable(snap_q) && $stable(stat_q))
      else $error("state moved while clock enable low");
endmodule
